// File: core/sts_dev.sv
/*
 Slave end: two-wire protocol engine on the link clock, temperature registers,
 hold timer and user ports on the core clock. Assumes the host keeps at least
 one SCL period between the address of a read and its data bit, so the fetch
 handshake completes in time.
*/
`include "sts_map.svh"

module sts_dev #(
    parameter int unsigned HOLD_CYCLES = `STS_HOLD_MS * `STS_CLK_KHZ
) (
    input wire logic clk,
    input wire logic nrst,
    sts_if.dev bus,
    input wire logic conv_valid,
    input wire logic [2:0] conv_chan,
    input wire logic [11:0] conv_temp,
    input wire logic conv_short,
    input wire logic [3:0] remote_sense_pos_input,
    input wire logic [3:0] remote_sense_neg_input,
    input wire logic alert_pending,
    input wire logic [7:0] user_rd_data,
    output logic [7:0] user_rd_index,
    output logic wr_strobe,
    output logic [7:0] wr_index,
    output logic [7:0] wr_value,
    output logic cmd_strobe,
    output logic [7:0] cmd_index,
    output logic alert_clear,
    output logic [3:0] diode_fault,
    output logic hold_active
);
    ////////////////////////////////////////////////////////////////////////////
    // Link side
    sts_pkg::sts_dstate_t dst;
    logic scl_s, sda_s, scl_p, sda_p;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic [1:0] byte_no;
    logic rw, ara, cmd_only, sda_drv;
    logic fet_tgl, wr_tgl, snd_tgl, clr_tgl;
    logic [7:0] wr_ptr, wr_dat;
    logic [7:0] tx_word;
    logic alert_s, ack_s, ack_q;
    logic ack_tgl;
    logic [7:0] rd_data;

    sts_sync #(.W(2), .INIT(2'h3)) u_pins (.clk(bus.link_clk), .nrst(nrst), .d({bus.scl, bus.sda}),
        .q({scl_s, sda_s}));
    sts_sync #(.W(2)) u_to_link (.clk(bus.link_clk), .nrst(nrst), .d({alert_pending, ack_tgl}),
        .q({alert_s, ack_s}));

    wire start_c = scl_s & scl_p & sda_p & ~sda_s;
    wire stop_c = scl_s & scl_p & ~sda_p & sda_s;
    wire rise = scl_s & ~scl_p;
    wire fall = ~scl_s & scl_p;
    wire addr_own = sh[7:1] == `STS_OWN_ADDR;
    wire addr_ara = (sh[7:1] == `STS_ARA_ADDR) & sh[0] & alert_s;
    wire [7:0] tx_first = ara ? {`STS_OWN_ADDR, 1'b0} : tx_word;

    assign bus.sda_out_d = 1'b0;
    assign bus.sda_oe_d = sda_drv;

    always_ff @(posedge bus.link_clk or negedge nrst) begin
        if (!nrst) begin
            scl_p <= 1'b1;
            sda_p <= 1'b1;
            ack_q <= 1'b0;
            tx_word <= `STS_TEMP_RST;
        end else begin
            scl_p <= scl_s;
            sda_p <= sda_s;
            ack_q <= ack_s;
            if (ack_s != ack_q) begin
                tx_word <= rd_data;
            end
        end
    end

    always_ff @(posedge bus.link_clk or negedge nrst) begin
        if (!nrst) begin
            dst <= sts_pkg::D_IDLE;
            cnt <= 4'h0;
            sh <= 8'h00;
            ptr <= `STS_PTR_RST;
            byte_no <= 2'h0;
            rw <= 1'b0;
            ara <= 1'b0;
            cmd_only <= 1'b0;
            sda_drv <= 1'b0;
            fet_tgl <= 1'b0;
            wr_tgl <= 1'b0;
            snd_tgl <= 1'b0;
            clr_tgl <= 1'b0;
            wr_ptr <= 8'h00;
            wr_dat <= 8'h00;
        end else if (start_c) begin
            dst <= sts_pkg::D_ADDR;
            cnt <= 4'h0;
            sda_drv <= 1'b0;
            cmd_only <= 1'b0;
        end else if (stop_c) begin
            dst <= sts_pkg::D_IDLE;
            sda_drv <= 1'b0;
            if (cmd_only) begin
                snd_tgl <= ~snd_tgl;
                cmd_only <= 1'b0;
            end
        end else begin
            unique case (dst)
                sts_pkg::D_IDLE, sts_pkg::D_SKIP: begin
                end
                sts_pkg::D_ADDR: begin
                    if (rise) begin
                        sh <= {sh[6:0], sda_s};
                        cnt <= cnt + 4'h1;
                    end else if (fall && cnt == 4'h8) begin
                        cnt <= 4'h0;
                        rw <= sh[0];
                        ara <= addr_ara;
                        if (addr_own || addr_ara) begin
                            sda_drv <= 1'b1;
                            dst <= sts_pkg::D_AACK;
                            if (addr_own && sh[0]) begin
                                fet_tgl <= ~fet_tgl;
                            end
                        end else begin
                            dst <= sts_pkg::D_SKIP;
                        end
                    end
                end
                sts_pkg::D_AACK: begin
                    if (fall) begin
                        if (rw) begin
                            sh <= {tx_first[6:0], 1'b0};
                            sda_drv <= ~tx_first[7];
                            cnt <= 4'h1;
                            dst <= sts_pkg::D_TX;
                        end else begin
                            sda_drv <= 1'b0;
                            byte_no <= 2'h0;
                            dst <= sts_pkg::D_RX;
                        end
                    end
                end
                sts_pkg::D_TX: begin
                    if (rise && !sda_drv && !sda_s) begin
                        dst <= sts_pkg::D_SKIP;
                    end else if (fall) begin
                        if (cnt == 4'h8) begin
                            sda_drv <= 1'b0;
                            dst <= sts_pkg::D_TACK;
                        end else begin
                            sda_drv <= ~sh[7];
                            sh <= {sh[6:0], 1'b0};
                            cnt <= cnt + 4'h1;
                        end
                    end
                end
                sts_pkg::D_TACK: begin
                    if (rise) begin
                        if (ara && sda_s) begin
                            clr_tgl <= ~clr_tgl;
                        end
                        dst <= sts_pkg::D_SKIP;
                    end
                end
                sts_pkg::D_RX: begin
                    if (rise) begin
                        sh <= {sh[6:0], sda_s};
                        cnt <= cnt + 4'h1;
                    end else if (fall && cnt == 4'h8) begin
                        cnt <= 4'h0;
                        if (byte_no == 2'h0) begin
                            ptr <= sh;
                            cmd_only <= 1'b1;
                            sda_drv <= 1'b1;
                            dst <= sts_pkg::D_RACK;
                        end else if (byte_no == 2'h1) begin
                            wr_ptr <= ptr;
                            wr_dat <= sh;
                            wr_tgl <= ~wr_tgl;
                            cmd_only <= 1'b0;
                            sda_drv <= 1'b1;
                            dst <= sts_pkg::D_RACK;
                        end else begin
                            dst <= sts_pkg::D_SKIP;
                        end
                    end
                end
                sts_pkg::D_RACK: begin
                    if (fall) begin
                        sda_drv <= 1'b0;
                        byte_no <= byte_no + 2'h1;
                        dst <= sts_pkg::D_RX;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Core side
    logic [3:0] tg_s, tg_p;
    logic [7:0] sense_s;
    logic fet_ph;
    logic [7:0] main_r [`STS_NCH];
    logic [7:0] ext_r;
    logic [31:0] hold_cnt;

    sts_sync #(.W(4)) u_to_core (.clk(clk), .nrst(nrst), .d({fet_tgl, wr_tgl, snd_tgl, clr_tgl}), .q(tg_s));
    sts_sync #(.W(8)) u_sense (.clk(clk), .nrst(nrst),
        .d({remote_sense_pos_input, remote_sense_neg_input}), .q(sense_s));

    wire [3:0] tg_e = tg_s ^ tg_p;
    wire [4:0] pos_x = {sense_s[7:4], 1'b0};
    wire [4:0] neg_x = {sense_s[3:0], 1'b0};
    wire chan_ok = conv_chan < 3'(`STS_NCH);
    wire chan_fault = conv_short | (chan_ok && pos_x[conv_chan] && neg_x[conv_chan]);
    wire t_neg = conv_temp[11];
    wire t_over = ~conv_temp[11] & conv_temp[10];
    wire [7:0] hi_val = chan_fault ? `STS_HI_FAULT :
        t_neg ? `STS_HI_MIN : t_over ? `STS_HI_MAX : conv_temp[10:3];
    wire [7:0] ext_val = (chan_fault | t_neg | t_over) ? 8'h00 : {conv_temp[2:0], `STS_EXT_LOW};
    wire idx_main = user_rd_index >= `STS_IDX_R1 && user_rd_index < 8'(`STS_NCH);
    wire [7:0] rd_mux = (user_rd_index == `STS_IDX_EXT) ? ext_r :
        (user_rd_index == `STS_IDX_LOCAL) ? main_r[0] :
        idx_main ? main_r[user_rd_index[2:0]] : user_rd_data;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tg_p <= 4'h0;
            fet_ph <= 1'b0;
            ack_tgl <= 1'b0;
            rd_data <= `STS_TEMP_RST;
            user_rd_index <= `STS_PTR_RST;
            wr_strobe <= 1'b0;
            wr_index <= 8'h00;
            wr_value <= 8'h00;
            cmd_strobe <= 1'b0;
            cmd_index <= 8'h00;
            alert_clear <= 1'b0;
        end else begin
            tg_p <= tg_s;
            fet_ph <= tg_e[3];
            if (tg_e[3]) begin
                user_rd_index <= ptr;
            end
            if (fet_ph) begin
                rd_data <= rd_mux;
                ack_tgl <= ~ack_tgl;
            end
            wr_strobe <= tg_e[2];
            if (tg_e[2]) begin
                wr_index <= wr_ptr;
                wr_value <= wr_dat;
            end
            cmd_strobe <= tg_e[1];
            if (tg_e[1]) begin
                cmd_index <= ptr;
            end
            alert_clear <= tg_e[0];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            hold_active <= 1'b0;
            hold_cnt <= 32'h0;
        end else if (fet_ph && user_rd_index == `STS_IDX_EXT) begin
            hold_active <= 1'b1;
            hold_cnt <= 32'h0;
        end else if (fet_ph && user_rd_index == `STS_IDX_R1) begin
            hold_active <= 1'b0;
        end else if (hold_active) begin
            hold_cnt <= hold_cnt + 32'h1;
            if (hold_cnt >= HOLD_CYCLES - 1) begin
                hold_active <= 1'b0;
            end
        end
    end

    generate
        for (genvar c = 0; c < `STS_NCH; c++) begin : g_chan
            wire upd = conv_valid && conv_chan == 3'(c);
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    main_r[c] <= `STS_TEMP_RST;
                end else if (upd && !(c == 1 && hold_active)) begin
                    main_r[c] <= hi_val;
                end
            end
            if (c == 1) begin : g_ext
                always_ff @(posedge clk or negedge nrst) begin
                    if (!nrst) begin
                        ext_r <= `STS_TEMP_RST;
                    end else if (upd) begin
                        ext_r <= ext_val;
                    end
                end
            end
            if (c > 0) begin : g_flt
                always_ff @(posedge clk or negedge nrst) begin
                    if (!nrst) begin
                        diode_fault[c-1] <= 1'b0;
                    end else if (upd) begin
                        diode_fault[c-1] <= chan_fault;
                    end
                end
            end
        end
    endgenerate
endmodule

// File: common/sts_map.svh
/*
 Constants of the SMBus temperature register slave: addresses, register indices,
 reset values and timing counts. Assumes a 125 MHz core clock and a host that
 builds its link clock and SCL from that clock.
*/
`ifndef STS_MAP_SVH
`define STS_MAP_SVH

// Own address is arbitrary; alert response address is the bus standard one
`define STS_OWN_ADDR 7'h2A
`define STS_ARA_ADDR 7'h0C

`define STS_IDX_R1 8'h01
`define STS_IDX_LOCAL 8'h07
`define STS_IDX_EXT 8'h08

`define STS_PTR_RST 8'h00
`define STS_TEMP_RST 8'h00
`define STS_HI_MAX 8'h7F
`define STS_HI_MIN 8'h00
`define STS_HI_FAULT 8'hFF
`define STS_EXT_LOW 5'h00

`define STS_NCH 5
`define STS_HOLD_MS 37
`define STS_CLK_KHZ 125000
`define STS_QTR_CYC 32

`endif

// File: common/sts_pkg.sv
/*
 Types of the SMBus temperature register slave: host operations, host tokens
 and the state set of the slave end. Assumes nothing of its surroundings.
*/
package sts_pkg;
    typedef enum logic [1:0] {OP_WRITE, OP_READ, OP_SEND, OP_RECV} sts_op_t;
    typedef enum logic [2:0] {T_START, T_ADDRW, T_ADDRR, T_CMD, T_DATA, T_READ, T_STOP} sts_tok_t;
    typedef enum logic [2:0] {D_IDLE, D_ADDR, D_AACK, D_RX, D_RACK, D_TX, D_TACK, D_SKIP} sts_dstate_t;
endpackage

// File: common/sts_if.sv
/*
 Two-wire link between host and slave, plus the link clock that the host
 makes. Resolves the open-drain SCL and SDA levels from the drivers' enables;
 both wires idle high as with pull-ups.
*/
interface sts_if;
    logic link_clk;
    logic scl_out_h;
    logic scl_oe_h;
    logic sda_out_h;
    logic sda_oe_h;
    logic sda_out_d;
    logic sda_oe_d;
    wire logic scl;
    wire logic sda;

    assign scl = ~(scl_oe_h & ~scl_out_h);
    assign sda = ~((sda_oe_h & ~sda_out_h) | (sda_oe_d & ~sda_out_d));

    modport host(output link_clk, output scl_out_h, output scl_oe_h, output sda_out_h, output sda_oe_h,
                 input scl, input sda);
    modport dev(input link_clk, input scl, input sda, output sda_out_d, output sda_oe_d);
endinterface

// File: core/sts_sync.sv
/*
 Two-flop synchroniser for levels and toggles. Assumes the input only changes
 slowly relative to the destination clock.
*/
module sts_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta <= INIT;
            q <= INIT;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

// File: core/sts_host.sv
/*
 Host end: makes the link clock by a divider, drives SCL and SDA as open
 drain, and runs one of the four byte protocols per request. Assumes a single
 master on the wires.
*/
`include "sts_map.svh"

module sts_host (
    input wire logic clk,
    input wire logic nrst,
    sts_if.host bus,
    input wire logic req,
    input wire sts_pkg::sts_op_t op,
    input wire logic [6:0] addr,
    input wire logic [7:0] cmd,
    input wire logic [7:0] wdata,
    output logic busy,
    output logic done,
    output logic nack,
    output logic [7:0] rdata
);
    function automatic sts_pkg::sts_tok_t tok_of(sts_pkg::sts_op_t o, logic [2:0] s);
        sts_pkg::sts_tok_t t;
        t = sts_pkg::T_STOP;
        if (s == 3'h0) begin
            t = sts_pkg::T_START;
        end else if (o == sts_pkg::OP_RECV) begin
            t = (s == 3'h1) ? sts_pkg::T_ADDRR : (s == 3'h2) ? sts_pkg::T_READ : sts_pkg::T_STOP;
        end else if (s == 3'h1) begin
            t = sts_pkg::T_ADDRW;
        end else if (s == 3'h2) begin
            t = sts_pkg::T_CMD;
        end else if (s == 3'h3 && o == sts_pkg::OP_WRITE) begin
            t = sts_pkg::T_DATA;
        end else if (o == sts_pkg::OP_READ) begin
            t = (s == 3'h3) ? sts_pkg::T_START : (s == 3'h4) ? sts_pkg::T_ADDRR :
                (s == 3'h5) ? sts_pkg::T_READ : sts_pkg::T_STOP;
        end
        return t;
    endfunction

    sts_pkg::sts_op_t op_q;
    logic [6:0] addr_q;
    logic [7:0] cmd_q, wdata_q;
    logic [2:0] sq;
    logic [1:0] ph;
    logic [3:0] bitn;
    logic [7:0] qc;
    logic abort_q;
    logic div, lclk, scl_lo, sda_lo, sda_q, sda_s;

    sts_sync #(.W(1), .INIT(1'b1)) u_sda (.clk(clk), .nrst(nrst), .d(bus.sda), .q(sda_s));

    wire sts_pkg::sts_tok_t tok = abort_q ? sts_pkg::T_STOP : tok_of(op_q, sq);
    wire is_byte = tok != sts_pkg::T_START && tok != sts_pkg::T_STOP;
    wire [7:0] tx_byte = (tok == sts_pkg::T_ADDRW) ? {addr_q, 1'b0} :
        (tok == sts_pkg::T_ADDRR) ? {addr_q, 1'b1} : (tok == sts_pkg::T_CMD) ? cmd_q : wdata_q;
    wire bit_lo = tok != sts_pkg::T_READ && bitn < 4'h8 && !tx_byte[3'h7 - bitn[2:0]];
    wire next_scl_lo = is_byte ? (ph < 2'h2) : (tok == sts_pkg::T_START) ? (ph == 2'h0 || ph == 2'h3) : (ph == 2'h0);
    wire next_sda_lo = is_byte ? bit_lo : (tok == sts_pkg::T_START) ? (ph >= 2'h2) : (ph <= 2'h1);
    wire slot_end = busy && qc == 8'(`STS_QTR_CYC - 1) && ph == 2'h3;

    assign bus.link_clk = lclk;
    assign bus.scl_out_h = 1'b0;
    assign bus.sda_out_h = 1'b0;
    assign bus.scl_oe_h = scl_lo;
    assign bus.sda_oe_h = sda_lo;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            div <= 1'b0;
            lclk <= 1'b0;
            scl_lo <= 1'b0;
            sda_q <= 1'b0;
            sda_lo <= 1'b0;
        end else begin
            div <= ~div;
            if (div) begin
                lclk <= ~lclk;
            end
            scl_lo <= busy & next_scl_lo;
            // Data lags SCL by one clock, so an SCL fall never looks like a start or stop
            sda_q <= busy & next_sda_lo;
            sda_lo <= sda_q;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            op_q <= sts_pkg::OP_WRITE;
            addr_q <= 7'h00;
            cmd_q <= 8'h00;
            wdata_q <= 8'h00;
            busy <= 1'b0;
            done <= 1'b0;
            nack <= 1'b0;
            rdata <= 8'h00;
            sq <= 3'h0;
            ph <= 2'h0;
            bitn <= 4'h0;
            qc <= 8'h00;
            abort_q <= 1'b0;
        end else begin
            done <= 1'b0;
            if (!busy) begin
                if (req) begin
                    op_q <= op;
                    addr_q <= addr;
                    cmd_q <= cmd;
                    wdata_q <= wdata;
                    busy <= 1'b1;
                    nack <= 1'b0;
                    abort_q <= 1'b0;
                    sq <= 3'h0;
                    ph <= 2'h0;
                    bitn <= 4'h0;
                    qc <= 8'h00;
                end
            end else if (qc != 8'(`STS_QTR_CYC - 1)) begin
                qc <= qc + 8'h01;
            end else begin
                qc <= 8'h00;
                ph <= ph + 2'h1;
                if (slot_end) begin
                    if (is_byte && bitn < 4'h8) begin
                        bitn <= bitn + 4'h1;
                        if (tok == sts_pkg::T_READ) begin
                            rdata <= {rdata[6:0], sda_s};
                        end
                    end else if (is_byte) begin
                        bitn <= 4'h0;
                        sq <= sq + 3'h1;
                        if (tok != sts_pkg::T_READ && sda_s) begin
                            nack <= 1'b1;
                            abort_q <= 1'b1;
                        end
                    end else if (tok == sts_pkg::T_STOP) begin
                        busy <= 1'b0;
                        done <= 1'b1;
                    end else begin
                        sq <= sq + 3'h1;
                    end
                end
            end
        end
    end
endmodule

// File: verification/sts_properties.sv
/*
 Concurrent checks on the two-wire link between host and slave ends.
 Assumes it sees the interface signals plus the core clock and reset.
*/
module sts_properties (
    input wire logic clk,
    input wire logic nrst,
    input wire logic link_clk,
    input wire logic scl_out_h,
    input wire logic scl_oe_h,
    input wire logic sda_out_h,
    input wire logic sda_oe_h,
    input wire logic sda_out_d,
    input wire logic sda_oe_d,
    input wire logic scl,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 1ps;

    a_host_open_drain: assert property (@(posedge clk) disable iff (!nrst) !scl_out_h && !sda_out_h)
        else $error("host drives a wire high");
    a_dev_open_drain: assert property (@(posedge clk) disable iff (!nrst) !sda_out_d)
        else $error("slave drives data high");
    a_dev_turn_scl_low: assert property (@(posedge link_clk) disable iff (!nrst) $changed(sda_oe_d) |-> !scl)
        else $error("slave data changed while clock high");
    a_one_driver_high: assert property (@(posedge clk) disable iff (!nrst) sda_oe_d && scl |-> !sda_oe_h)
        else $error("host and slave both drive data");
    a_idle_after_reset: assert property (@(posedge clk) disable iff (!nrst) $rose(nrst) |-> scl && sda && !sda_oe_d)
        else $error("wires not idle after reset");
    a_scl_low_min: assert property (@(posedge clk) disable iff (!nrst) $fell(scl) |=> !scl [* 8])
        else $error("clock low phase too short");
    a_scl_high_min: assert property (@(posedge clk) disable iff (!nrst) $rose(scl) |=> scl [* 8])
        else $error("clock high phase too short");
    a_scl_low_max: assert property (@(posedge clk) disable iff (!nrst) $fell(scl) |-> ##[1:200] scl)
        else $error("clock held low too long");
    a_start_no_slave: assert property (@(posedge clk) disable iff (!nrst) $fell(sda) && scl |-> !sda_oe_d)
        else $error("slave drives during a start");
    a_dev_release: assert property (@(posedge link_clk) disable iff (!nrst)
        $rose(sda_oe_d) |-> ##[1:400] !sda_oe_d)
        else $error("slave never releases data");

    c_slave_drive: cover property (@(posedge link_clk) disable iff (!nrst) $rose(sda_oe_d));
    c_start: cover property (@(posedge clk) disable iff (!nrst) $fell(sda) && scl);
    c_slave_high: cover property (@(posedge clk) disable iff (!nrst) sda_oe_d && scl);
endmodule

// File: verification/tb_top.sv
/*
 Self-checking bench: host end and slave end joined by the link.
 Assumes the host makes the link clock from clk.
*/
`include "sts_map.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); end end

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HOLD = 8000;
    logic clk = 0, nrst = 0, req = 0, busy, done, nack;
    sts_pkg::sts_op_t op = sts_pkg::OP_WRITE;
    logic [6:0] addr = 7'h00;
    logic [7:0] cmd = 8'h00, wdata = 8'h00, rdata, rd_index, rd_data, wr_index, wr_value, cmd_index;
    logic [7:0] cmd_seen = 8'h00;
    logic [15:0] wr_seen = 16'h0000;
    logic conv_valid = 0, conv_short = 0, alert_pending = 0, wr_strobe, cmd_strobe, alert_clear, hold_active;
    logic [2:0] conv_chan = 3'h0;
    logic [11:0] conv_temp = 12'h000;
    logic [3:0] sense_pos = 4'h0, sense_neg = 4'h0, diode_fault;
    logic [7:0] ridx [6] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h07, 8'h08};
    logic [7:0] rexp [6] = '{8'h19, 8'h7F, 8'hFF, 8'hFF, 8'h00, 8'h80};
    int fails = 0, checked = 0, cyc = 0, clr_n = 0;

    // Data seen for indices the slave does not hold itself
    assign rd_data = rd_index ^ 8'hA5;

    always #4 clk = ~clk;

    sts_if lnk();
    sts_host sts_host_i (.clk(clk), .nrst(nrst), .bus(lnk), .req(req), .op(op), .addr(addr), .cmd(cmd),
        .wdata(wdata), .busy(busy), .done(done), .nack(nack), .rdata(rdata));
    sts_dev #(.HOLD_CYCLES(HOLD)) sts_dev_i (.clk(clk), .nrst(nrst), .bus(lnk), .conv_valid(conv_valid),
        .conv_chan(conv_chan), .conv_temp(conv_temp), .conv_short(conv_short),
        .remote_sense_pos_input(sense_pos), .remote_sense_neg_input(sense_neg), .alert_pending(alert_pending),
        .user_rd_data(rd_data), .user_rd_index(rd_index), .wr_strobe(wr_strobe), .wr_index(wr_index),
        .wr_value(wr_value), .cmd_strobe(cmd_strobe), .cmd_index(cmd_index), .alert_clear(alert_clear),
        .diode_fault(diode_fault), .hold_active(hold_active));
    sts_properties sts_properties_i (.clk(clk), .nrst(nrst), .link_clk(lnk.link_clk), .scl_out_h(lnk.scl_out_h),
        .scl_oe_h(lnk.scl_oe_h), .sda_out_h(lnk.sda_out_h), .sda_oe_h(lnk.sda_oe_h), .sda_out_d(lnk.sda_out_d),
        .sda_oe_d(lnk.sda_oe_d), .scl(lnk.scl), .sda(lnk.sda));

    ////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic xfer(input sts_pkg::sts_op_t o, input logic [6:0] a, input logic [7:0] c, input logic [7:0] d);
        @(posedge clk);
        #1;
        req = 1;
        op = o;
        addr = a;
        cmd = c;
        wdata = d;
        @(posedge clk);
        #1;
        req = 0;
        for (int i = 0; i < 10000 && done !== 1'b1; i++) @(negedge clk);
        if (done !== 1'b1) fails++;
    endtask

    task automatic conv(input logic [2:0] ch, input logic [11:0] t, input logic s);
        @(posedge clk);
        #1;
        conv_valid = 1;
        conv_chan = ch;
        conv_temp = t;
        conv_short = s;
        @(posedge clk);
        #1;
        conv_valid = 0;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (wr_strobe === 1'b1) wr_seen = {wr_index, wr_value};
        if (cmd_strobe === 1'b1) cmd_seen = cmd_index;
        if (alert_clear === 1'b1) clr_n++;
        if (cyc == 90000) begin
            fails++;
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge clk);
        #1;
        nrst = 1;
        repeat (2) @(posedge clk);
        xfer(sts_pkg::OP_RECV, `STS_OWN_ADDR, 8'h00, 8'h00);
        `CHK("pointer at reset", 8'hA5, rdata)
        `CHK("host idle", 1'b0, busy)
        xfer(sts_pkg::OP_WRITE, `STS_OWN_ADDR, 8'h10, 8'h5C);
        `CHK("write byte", 16'h105C, wr_seen)
        `CHK("write ack", 1'b0, nack)
        xfer(sts_pkg::OP_SEND, `STS_OWN_ADDR, 8'h33, 8'h00);
        `CHK("send byte", 8'h33, cmd_seen)
        xfer(sts_pkg::OP_RECV, `STS_OWN_ADDR, 8'h00, 8'h00);
        `CHK("receive byte", 8'h96, rdata)
        @(posedge clk);
        #1;
        sense_pos = 4'h4;
        sense_neg = 4'h4;
        repeat (5) @(posedge clk);
        conv(3'h1, 12'h0CC, 1'b0);
        conv(3'h2, 12'h400, 1'b0);
        conv(3'h3, 12'h0C8, 1'b0);
        conv(3'h4, 12'h0C8, 1'b1);
        conv(3'h0, 12'hF00, 1'b0);
        `CHK("fault flags", 4'hC, diode_fault)
        foreach (ridx[i]) begin
            xfer(sts_pkg::OP_READ, `STS_OWN_ADDR, ridx[i], 8'h00);
            `CHK("temperature", rexp[i], rdata)
        end
        `CHK("hold set", 1'b1, hold_active)
        conv(3'h1, 12'h0F0, 1'b0);
        xfer(sts_pkg::OP_READ, `STS_OWN_ADDR, 8'h01, 8'h00);
        `CHK("held high byte", 8'h19, rdata)
        `CHK("hold cleared", 1'b0, hold_active)
        xfer(sts_pkg::OP_READ, `STS_OWN_ADDR, 8'h08, 8'h00);
        `CHK("extended update", 8'h00, rdata)
        `CHK("hold still set", 1'b1, hold_active)
        repeat (HOLD + 10) @(posedge clk);
        `CHK("hold expired", 1'b0, hold_active)
        conv(3'h1, 12'h0F8, 1'b0);
        xfer(sts_pkg::OP_READ, `STS_OWN_ADDR, 8'h01, 8'h00);
        `CHK("updates resumed", 8'h1F, rdata)
        wr_seen = 16'h0000;
        xfer(sts_pkg::OP_WRITE, 7'h11, 8'h22, 8'h33);
        `CHK("foreign nack", 1'b1, nack)
        `CHK("foreign no write", 16'h0000, wr_seen)
        @(posedge clk);
        #1;
        alert_pending = 1;
        repeat (5) @(posedge clk);
        xfer(sts_pkg::OP_RECV, `STS_ARA_ADDR, 8'h00, 8'h00);
        `CHK("alert reply", {`STS_OWN_ADDR, 1'b0}, rdata)
        `CHK("alert clear count", 32'h1, clr_n)
        stop_test();
    end
endmodule
